/* File: hw/sar_link_pkg.sv */
`default_nettype none
package sar_link_pkg;
	localparam int SYS_CLK_MHZ = 125;
	localparam int RESULT_BITS = 10;
	localparam int SUB_BITS = 2;
	localparam int FRAME_EDGES = 13;
	// conversion time excluding acquisition, in ns
	localparam int CONV_TIME_NS = 9000;
	localparam int CONV_CYCLES = (CONV_TIME_NS * SYS_CLK_MHZ) / 1000;
	// least serial clock phase, in ns
	localparam int SCLK_PHASE_NS = 200;
	localparam int SCLK_PHASE_CYCLES = (SCLK_PHASE_NS * SYS_CLK_MHZ + 999) / 1000;
	// least acquisition interval between conversions, in ns
	localparam int ACQ_TIME_NS = 1500;
	localparam int ACQ_CYCLES = (ACQ_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
	// wake-up time after leaving shutdown, in ns
	localparam int WAKE_TIME_NS = 4000;
	localparam int WAKE_CYCLES = (WAKE_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
	// power-up wait with external reference, in ns
	localparam int PWRUP_EXT_NS = 10000;
	localparam int PWRUP_EXT_CYCLES = (PWRUP_EXT_NS * SYS_CLK_MHZ + 999) / 1000;
	// power-up wait with internal reference, in ms
	localparam int PWRUP_INT_MS = 20;
	localparam int PWRUP_INT_CYCLES = PWRUP_INT_MS * SYS_CLK_MHZ * 1000;
	localparam int CNT_W = 24;
	localparam int BIT_CNT_W = 5;
	typedef enum logic [1:0] {
		DEV_IDLE = 2'b00,
		DEV_CONV = 2'b01,
		DEV_SHIFT = 2'b11
	} dev_state_t;
	typedef enum logic [2:0] {
		HST_WAIT = 3'b000,
		HST_READY = 3'b001,
		HST_CONV = 3'b011,
		HST_CLK_HI = 3'b010,
		HST_CLK_LO = 3'b110,
		HST_ACQ = 3'b111
	} host_state_t;
endpackage : sar_link_pkg
`default_nettype wire

/* File: hw/sar_link_if.sv */
`default_nettype none
interface sar_link_if;
	logic cs_n;
	logic sclk;
	logic dout_o;
	logic dout_oe;
	logic power_down_n_o;
	logic power_down_n_oe;
	// floating data line reads low at the host; floating power-down reads high
	logic dout;
	logic power_down_n;
	assign dout = dout_oe ? dout_o : 1'b0;
	assign power_down_n = power_down_n_oe ? power_down_n_o : 1'b1;
	modport adc (
		input cs_n,
		input sclk,
		input power_down_n,
		input power_down_n_oe,
		output dout_o,
		output dout_oe
	);
	modport mcu (
		output cs_n,
		output sclk,
		output power_down_n_o,
		output power_down_n_oe,
		input dout
	);
endinterface : sar_link_if
`default_nettype wire

/* File: hw/sar_adc_end.sv */
`default_nettype none
// How it works
// [RULE_01] select falling edge: hold and start conversion
// [RULE_02] conversion done within 9us, 10-bit result
// [RULE_03] conversion timed internally, no serial clock
// [RULE_04] completion shown by output going high
// [RULE_05] stream: high bit then result MSB first
// [RULE_06] one bit shifted per external clock
// [RULE_07] master keeps clock idle during conversion
// [RULE_08] master clock rate at most 2.1MHz
// [RULE_09] clock high and low each at least 200ns
// [RULE_10] conversion end reconnects sampling capacitor
// [RULE_11] master allows at least 1.5us acquisition
// [RULE_12] power-down low means shutdown, else normal
// [RULE_13] high enables internal reference, floating disables
// [RULE_14] master waits wake-up after leaving shutdown
// [RULE_15] wake-up about 4us with external reference
// [RULE_16] external reference: wait 10us after power-up
// [RULE_17] internal reference: wait up to 20ms; the host waits PWRUP_CNT, 10us by default, with either reference
// [RULE_18] select fall drives output low while converting
// [RULE_19] output changes on clock fall, off when deselected
// [RULE_20] at least 13 falling edges read frame
// [RULE_21] extra edges shift zeros, harmless
// [RULE_22] shutdown ignores link, output stays off
module sar_adc_end
	import sar_link_pkg::*;
#(
	parameter int CONV_CNT = sar_link_pkg::CONV_CYCLES
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// link
	sar_link_if.adc link,
	// analog sample stands in as a digital code
	input wire logic [sar_link_pkg::RESULT_BITS-1:0] sample_code,
	// status
	output logic hold_q,
	output logic shutdown_q,
	output logic int_ref_en_q,
	output logic [sar_link_pkg::RESULT_BITS-1:0] result_q
);
	import sar_link_pkg::*;

	localparam int SHIFT_W = RESULT_BITS + SUB_BITS + 1;

	dev_state_t state_q;
	logic [2:0] cs_sync_q;
	logic [2:0] sclk_sync_q;
	logic [1:0] pd_sync_q;
	logic [1:0] pd_oe_sync_q;
	logic [CNT_W-1:0] conv_cnt_q;
	logic [SHIFT_W-1:0] shift_q;
	logic cs_fall;
	logic cs_high;
	logic sclk_fall;
	logic pd_low;

	// edge logic compares the two oldest stages of the select and clock chains; cs_high reads the middle stage
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			cs_sync_q <= 3'h7;
			sclk_sync_q <= 3'h0;
			pd_sync_q <= 2'h3;
			pd_oe_sync_q <= 2'h0;
		end else begin
			cs_sync_q <= {cs_sync_q[1:0], link.cs_n};
			sclk_sync_q <= {sclk_sync_q[1:0], link.sclk};
			pd_sync_q <= {pd_sync_q[0], link.power_down_n};
			pd_oe_sync_q <= {pd_oe_sync_q[0], link.power_down_n_oe};
		end
	end

	assign cs_fall = cs_sync_q[2] && !cs_sync_q[1];
	assign cs_high = cs_sync_q[1];
	assign sclk_fall = sclk_sync_q[2] && !sclk_sync_q[1];
	assign pd_low = !pd_sync_q[1];

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			shutdown_q <= 1'b0;
			int_ref_en_q <= 1'b0;
		end else begin
			shutdown_q <= pd_low; // [RULE_12]
			// a driven high enables the reference; released pin means external
			int_ref_en_q <= pd_sync_q[1] && pd_oe_sync_q[1]; // [RULE_13]
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			state_q <= DEV_IDLE;
			hold_q <= 1'b0;
			conv_cnt_q <= '0;
			shift_q <= '0;
			result_q <= '0;
		end else if (pd_low || cs_high) begin
			// shutdown or deselect aborts any conversion
			state_q <= DEV_IDLE; // [RULE_22]
			hold_q <= 1'b0;
			conv_cnt_q <= '0;
		end else begin
			case (state_q)
				DEV_IDLE: begin
					if (cs_fall) begin
						state_q <= DEV_CONV; // [RULE_01]
						hold_q <= 1'b1; // [RULE_01]
						result_q <= sample_code;
						conv_cnt_q <= '0;
					end
				end
				DEV_CONV: begin
					// serial clock is not looked at while converting
					if (conv_cnt_q == CNT_W'(CONV_CNT - 1)) begin // [RULE_02] [RULE_03]
						state_q <= DEV_SHIFT;
						hold_q <= 1'b0; // [RULE_10]
						shift_q <= {1'b1, result_q, SUB_BITS'(0)}; // [RULE_04] [RULE_05]
					end else begin
						conv_cnt_q <= conv_cnt_q + CNT_W'(1);
					end
				end
				DEV_SHIFT: begin
					if (sclk_fall) begin
						// sub-bits are zero; later edges feed zeros in
						shift_q <= {shift_q[SHIFT_W-2:0], 1'b0}; // [RULE_06] [RULE_19] [RULE_20] [RULE_21]
					end
				end
				default: begin
					state_q <= DEV_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			link.dout_o <= 1'b0;
			link.dout_oe <= 1'b0;
		end else begin
			link.dout_oe <= !pd_low && !cs_high && (state_q != DEV_IDLE || cs_fall); // [RULE_18] [RULE_19] [RULE_22]
			link.dout_o <= (state_q == DEV_SHIFT) ? shift_q[SHIFT_W-1] : 1'b0; // [RULE_18]
		end
	end
endmodule : sar_adc_end
`default_nettype wire

/* File: hw/sar_mcu_end.sv */
`default_nettype none
module sar_mcu_end
	import sar_link_pkg::*;
#(
	parameter int PWRUP_CNT = sar_link_pkg::PWRUP_EXT_CYCLES,
	parameter int WAKE_CNT = sar_link_pkg::WAKE_CYCLES,
	parameter int ACQ_CNT = sar_link_pkg::ACQ_CYCLES,
	parameter int HALF_CNT = sar_link_pkg::SCLK_PHASE_CYCLES + 35,
	parameter int READ_EDGES = sar_link_pkg::FRAME_EDGES
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// link
	sar_link_if.mcu link,
	// user side
	input wire logic start,
	input wire logic shutdown_req,
	input wire logic use_int_ref,
	output logic busy_q,
	output logic done_q,
	output logic [sar_link_pkg::RESULT_BITS-1:0] data_q
);
	import sar_link_pkg::*;

	host_state_t state_q;
	logic [1:0] dout_sync_q;
	logic [CNT_W-1:0] cnt_q;
	logic [BIT_CNT_W-1:0] edge_q;
	logic [RESULT_BITS+SUB_BITS-1:0] rx_q;
	logic shut_q;

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			dout_sync_q <= 2'h0;
		end else begin
			dout_sync_q <= {dout_sync_q[0], link.dout};
		end
	end

	// high when drive selects internal reference, released for external
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			link.power_down_n_o <= 1'b1;
			link.power_down_n_oe <= 1'b0;
			shut_q <= 1'b0;
		end else begin
			shut_q <= shutdown_req && (state_q == HST_READY || state_q == HST_WAIT);
			link.power_down_n_o <= !(shut_q || shutdown_req); // [RULE_12]
			link.power_down_n_oe <= shut_q || shutdown_req || use_int_ref; // [RULE_13]
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			state_q <= HST_WAIT;
			cnt_q <= CNT_W'(PWRUP_CNT); // [RULE_16] [RULE_17]
			edge_q <= '0;
			rx_q <= '0;
			link.cs_n <= 1'b1;
			link.sclk <= 1'b0;
			busy_q <= 1'b1;
			done_q <= 1'b0;
			data_q <= '0;
		end else begin
			done_q <= 1'b0;
			case (state_q)
				HST_WAIT: begin
					if (shut_q) begin
						cnt_q <= CNT_W'(WAKE_CNT); // [RULE_14] [RULE_15]
					end else if (cnt_q == '0) begin
						state_q <= HST_READY;
						busy_q <= 1'b0;
					end else begin
						cnt_q <= cnt_q - CNT_W'(1);
					end
				end
				HST_READY: begin
					if (shut_q) begin
						state_q <= HST_WAIT;
						busy_q <= 1'b1;
						cnt_q <= CNT_W'(WAKE_CNT);
					end else if (start && !shutdown_req) begin
						state_q <= HST_CONV;
						busy_q <= 1'b1;
						link.cs_n <= 1'b0;
						edge_q <= '0;
					end
				end
				HST_CONV: begin
					// clock held low until completion bit seen
					link.sclk <= 1'b0; // [RULE_07]
					if (dout_sync_q[1]) begin
						state_q <= HST_CLK_HI;
						cnt_q <= CNT_W'(HALF_CNT);
					end
				end
				HST_CLK_HI: begin
					if (cnt_q == '0) begin
						link.sclk <= 1'b1;
						// sample on rising edge; data settled since last fall
						if (edge_q != '0) begin
							rx_q <= {rx_q[RESULT_BITS+SUB_BITS-2:0], dout_sync_q[1]}; // [RULE_06]
						end
						state_q <= HST_CLK_LO;
						cnt_q <= CNT_W'(HALF_CNT); // [RULE_08] [RULE_09]
					end else begin
						cnt_q <= cnt_q - CNT_W'(1);
					end
				end
				HST_CLK_LO: begin
					if (cnt_q == '0) begin
						link.sclk <= 1'b0;
						edge_q <= edge_q + BIT_CNT_W'(1);
						cnt_q <= CNT_W'(HALF_CNT); // [RULE_09]
						if (edge_q == BIT_CNT_W'(READ_EDGES - 1)) begin // [RULE_20]
							state_q <= HST_ACQ;
							link.cs_n <= 1'b1;
							cnt_q <= CNT_W'(ACQ_CNT); // [RULE_11]
						end else begin
							state_q <= HST_CLK_HI;
						end
					end else begin
						cnt_q <= cnt_q - CNT_W'(1);
					end
				end
				HST_ACQ: begin
					if (edge_q == BIT_CNT_W'(READ_EDGES)) begin
						data_q <= rx_q[RESULT_BITS+SUB_BITS-1:SUB_BITS]; // [RULE_05]
						done_q <= 1'b1;
						edge_q <= '0;
					end
					if (cnt_q == '0) begin
						state_q <= HST_READY;
						busy_q <= 1'b0;
					end else begin
						cnt_q <= cnt_q - CNT_W'(1);
					end
				end
				default: begin
					state_q <= HST_WAIT;
				end
			endcase
		end
	end
endmodule : sar_mcu_end
`default_nettype wire

/* File: tb/sar_link_assertions.sv */
`default_nettype none
module sar_link_assertions (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// link
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic dout_o,
	input wire logic dout_oe,
	input wire logic power_down_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// a little slack over the nominal conversion count for the registered data output
	localparam int CONV_LIM = 1130;
	logic conv_q;
	logic [10:0] conv_cnt_q;
	logic [7:0] hi_cnt_q;
	logic [7:0] ph_cnt_q;
	logic [3:0] fall_age_q;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	always_ff @(posedge sys_clk) begin
		if (!rstn || cs_n || dout_o) conv_q <= 1'b0;
		else if ($rose(dout_oe)) conv_q <= 1'b1;
	end
	always_ff @(posedge sys_clk) begin
		if (!rstn || !conv_q) conv_cnt_q <= 11'h000;
		else conv_cnt_q <= conv_cnt_q + 11'h001;
	end
	always_ff @(posedge sys_clk) begin
		if (!rstn || !cs_n) hi_cnt_q <= 8'h00;
		else if (hi_cnt_q != 8'hFF) hi_cnt_q <= hi_cnt_q + 8'h01;
	end
	// counters saturate so a long idle spell cannot wrap into a false short phase
	always_ff @(posedge sys_clk) begin
		if (!rstn || $changed(sclk)) ph_cnt_q <= 8'h00;
		else if (ph_cnt_q != 8'hFF) ph_cnt_q <= ph_cnt_q + 8'h01;
	end
	always_ff @(posedge sys_clk) begin
		if (!rstn || $fell(sclk)) fall_age_q <= 4'h0;
		else if (fall_age_q != 4'hF) fall_age_q <= fall_age_q + 4'h1;
	end
	property p_idle_off;
		cs_n [*4] |-> !dout_oe;
	endproperty
	a_idle_off: assert property (p_idle_off) else $error("output driven while deselected");
	property p_low_on_select;
		$fell(cs_n) && power_down_n |-> ##[1:6] (dout_oe && !dout_o);
	endproperty
	a_low_on_select: assert property (p_low_on_select) else $error("no low after select");
	property p_conv_time;
		conv_cnt_q <= CONV_LIM;
	endproperty
	a_conv_time: assert property (p_conv_time) else $error("conversion too long");
	property p_clk_idle;
		conv_q |-> !sclk;
	endproperty
	a_clk_idle: assert property (p_clk_idle) else $error("clock ran in conversion");
	property p_shift_on_fall;
		dout_oe && $past(dout_oe) && $changed(dout_o) && !$past(conv_q) |-> fall_age_q <= 4'h6;
	endproperty
	a_shift_on_fall: assert property (p_shift_on_fall) else $error("data moved off fall");
	property p_phase;
		$changed(sclk) |-> ph_cnt_q >= 8'h18;
	endproperty
	a_phase: assert property (p_phase) else $error("clock phase too short");
	property p_acq;
		$fell(cs_n) |-> hi_cnt_q >= 8'hBB;
	endproperty
	a_acq: assert property (p_acq) else $error("acquisition gap too short");
	property p_shutdown;
		!power_down_n [*4] |-> !dout_oe;
	endproperty
	a_shutdown: assert property (p_shutdown) else $error("output driven in shutdown");
	c_eoc: cover property ($rose(dout_o) && !cs_n);
	c_down: cover property ($fell(power_down_n));
	c_frame_end: cover property ($rose(cs_n) && dout_oe);
endmodule : sar_link_assertions
`default_nettype wire

/* File: tb/testbench.sv */
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import sar_link_pkg::*;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic start = 1'b0;
	logic shutdown_req = 1'b0;
	logic use_int_ref = 1'b0;
	logic [RESULT_BITS-1:0] sample_code = 10'h000;
	logic hold_q, shutdown_q, int_ref_en_q, busy_q, done_q;
	logic [RESULT_BITS-1:0] result_q, data_q;
	int failures = 0;
	int num_checks = 0;
	sar_link_if link ();
	sar_adc_end sar_adc_end_i (.sys_clk(sys_clk), .rstn(rstn), .link(link),
		.sample_code(sample_code), .hold_q(hold_q), .shutdown_q(shutdown_q),
		.int_ref_en_q(int_ref_en_q), .result_q(result_q));
	// power-up wait kept above the acquisition gap so the first start is legal
	// short waits keep the run small; the ordering they enforce is what is checked
	sar_mcu_end #(.PWRUP_CNT(200), .WAKE_CNT(10)) sar_mcu_end_i (.sys_clk(sys_clk),
		.rstn(rstn), .link(link), .start(start), .shutdown_req(shutdown_req),
		.use_int_ref(use_int_ref), .busy_q(busy_q), .done_q(done_q), .data_q(data_q));
	sar_link_assertions sar_link_assertions_i (.sys_clk(sys_clk), .rstn(rstn),
		.cs_n(link.cs_n), .sclk(link.sclk), .dout_o(link.dout_o), .dout_oe(link.dout_oe),
		.power_down_n(link.power_down_n));
	initial begin
		forever #4 sys_clk = ~sys_clk;
	end
	task automatic results();
		if (failures == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : results
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// wait on busy or done; a stuck handshake ends the run
	task automatic wait_on(input logic want_done);
		int n;
		n = 0;
		while (want_done ? (done_q !== 1'b1) : (busy_q !== 1'b0)) begin
			@(posedge sys_clk);
			n++;
			if (n > 6000) begin
				failures++;
				results();
			end
		end
	endtask : wait_on
	task automatic convert(input logic [9:0] code);
		wait_on(1'b0);
		sample_code <= code;
		start <= 1'b1;
		@(posedge sys_clk);
		start <= 1'b0;
		repeat (20) @(posedge sys_clk);
		chk(hold_q, 1'b1);
		wait_on(1'b1);
		chk(data_q, code);
		chk(result_q, code);
		chk(hold_q, 1'b0);
	endtask : convert
	// boundary and bit-pattern codes back to back, so the acquisition gap is the only spacing
	task automatic t_codes();
		convert(10'h3FF);
		convert(10'h000);
		convert(10'h201);
		convert(10'h155);
	endtask : t_codes
	task automatic t_ref();
		use_int_ref <= 1'b1;
		convert(10'h2AA);
		chk(int_ref_en_q, 1'b1);
		use_int_ref <= 1'b0;
		convert(10'h0F0);
		chk(int_ref_en_q, 1'b0);
	endtask : t_ref
	task automatic t_shutdown();
		wait_on(1'b0);
		shutdown_req <= 1'b1;
		repeat (40) @(posedge sys_clk);
		chk(link.power_down_n, 1'b0);
		chk(shutdown_q, 1'b1);
		chk(link.dout_oe, 1'b0);
		shutdown_req <= 1'b0;
		convert(10'h3C3);
		chk(shutdown_q, 1'b0);
	endtask : t_shutdown
	initial begin
		repeat (8) @(posedge sys_clk);
		rstn <= 1'b1;
		t_codes();
		t_ref();
		t_shutdown();
		results();
	end
endmodule : testbench
`default_nettype wire
